// ---- src/mdsc_pkg.sv ----
// constants and types for the module disable and sleep control block
package mdsc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] MDSC_CLOCK_CONTROL_OFFSET = 32'h0000_0000;
  localparam int          MDSC_DISABLE_REQUEST_BIT  = 0;
  localparam int          MDSC_DISABLE_STATUS_BIT   = 1;
  localparam int          MDSC_SLEEP_IGNORE_BIT     = 3;
  localparam logic        MDSC_DISABLE_REQUEST_RST  = 1'b0;
  localparam logic        MDSC_SLEEP_IGNORE_RST     = 1'b0;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] MDSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MDSC_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int MDSC_CLK_PERIOD_NS = 50;
  localparam int MDSC_DRAIN_TIME_NS = 200;
  localparam int MDSC_DRAIN_CYCLES  =
    (MDSC_DRAIN_TIME_NS + MDSC_CLK_PERIOD_NS - 1) / MDSC_CLK_PERIOD_NS;
  localparam logic [3:0] MDSC_DRAIN_LAST = 4'(MDSC_DRAIN_CYCLES - 1);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum { MDSC_VAR_FULL, MDSC_VAR_NONE, MDSC_VAR_STORAGE } mdsc_variant_e;

  typedef struct packed {
    logic sleep_ignore;
    logic disable_status;
    logic disable_request;
  } mdsc_ctrl_s;

endpackage : mdsc_pkg

// ---- src/mdsc_stop_seq.sv ----
// functional clock stop sequencer
`timescale 1ns/1ps
`default_nettype none
module mdsc_stop_seq
  import mdsc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // control
  input  wire logic stop_i,
  // state
  output var  logic clk_en_o,
  output var  logic stopped_o
);

  typedef enum { MDSC_ST_RUN, MDSC_ST_DRAIN, MDSC_ST_STOPPED } mdsc_state_e;

  mdsc_state_e state_reg;
  mdsc_state_e state_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      MDSC_ST_RUN: begin
        cnt_next = 4'h0;
        if (stop_i) begin
          state_next = MDSC_ST_DRAIN;
        end
      end
      MDSC_ST_DRAIN: begin
        // gate is off, wait for it to settle before reporting stopped
        if (!stop_i) begin
          state_next = MDSC_ST_RUN;
        end else if (cnt_reg == MDSC_DRAIN_LAST) begin
          state_next = MDSC_ST_STOPPED;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      MDSC_ST_STOPPED: begin
        if (!stop_i) begin
          state_next = MDSC_ST_RUN;
        end
      end
      default: begin
        state_next = MDSC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= MDSC_ST_RUN;
      cnt_reg   <= 4'h0;
      clk_en_o  <= 1'b1;
      stopped_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      clk_en_o  <= (state_next == MDSC_ST_RUN);
      stopped_o <= (state_next == MDSC_ST_STOPPED);
    end
  end

endmodule : mdsc_stop_seq
`default_nettype wire

// ---- src/mdsc_top.sv ----
// module disable and sleep control with AXI4-Lite register access
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module mdsc_top
  import mdsc_pkg::*;
#(
  parameter mdsc_variant_e VARIANT = MDSC_VAR_FULL
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // axi4-lite write address and data
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output var  logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output var  logic        s_axi_wready_o,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp_o,
  output var  logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output var  logic        s_axi_arready_o,
  output var  logic [31:0] s_axi_rdata_o,
  output var  logic [1:0]  s_axi_rresp_o,
  output var  logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // system sleep and module clock
  input  wire logic        sleep_req_i,
  output var  logic        func_clk_en_o,
  output var  logic        sleep_o,
  output var  logic        disabled_o
);

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  logic        aw_held_reg, aw_held_next;
  logic        w_held_reg, w_held_next;
  logic [31:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        wstrb0_reg, wstrb0_next;
  logic        bvalid_next;
  logic [1:0]  bresp_next;
  logic        wr_do;
  logic        wr_hit;

  assign wr_do  = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
  assign wr_hit = (awaddr_reg == MDSC_CLOCK_CONTROL_OFFSET);

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bvalid_next  = s_axi_bvalid_o;
    bresp_next   = s_axi_bresp_o;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata_i;
      wstrb0_next = s_axi_wstrb_i[0];
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (wr_do) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_hit ? MDSC_RESP_OKAY : MDSC_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      awaddr_reg      <= 32'h0000_0000;
      wdata_reg       <= 32'h0000_0000;
      wstrb0_reg      <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= MDSC_RESP_OKAY;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      awaddr_reg      <= awaddr_next;
      wdata_reg       <= wdata_next;
      wstrb0_reg      <= wstrb0_next;
      s_axi_bvalid_o  <= bvalid_next;
      s_axi_bresp_o   <= bresp_next;
      s_axi_awready_o <= !aw_held_next && !bvalid_next;
      s_axi_wready_o  <= !w_held_next && !bvalid_next;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  mdsc_ctrl_s ctrl_reg, ctrl_next;
  logic       stopped;
  logic       ign_eff;
  logic       sleep_act;
  logic       stop_req;

  // only the full variant lets the ignore bit steer sleep
  assign ign_eff   = (VARIANT == MDSC_VAR_FULL) && ctrl_reg.sleep_ignore;
  assign sleep_act = sleep_req_i && !ign_eff;
  assign stop_req  = ctrl_reg.disable_request || sleep_act;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_do && wr_hit && wstrb0_reg) begin
      ctrl_next.disable_request = wdata_reg[MDSC_DISABLE_REQUEST_BIT];
      if (VARIANT != MDSC_VAR_NONE) begin
        ctrl_next.sleep_ignore = wdata_reg[MDSC_SLEEP_IGNORE_BIT];
      end
    end
    // status follows the stopped clock while disable is requested, never the written status bit
    ctrl_next.disable_status = stopped && ctrl_reg.disable_request;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_reg.disable_request <= MDSC_DISABLE_REQUEST_RST;
      ctrl_reg.disable_status  <= 1'b0;
      ctrl_reg.sleep_ignore    <= MDSC_SLEEP_IGNORE_RST;
      disabled_o               <= 1'b0;
      sleep_o                  <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      disabled_o <= ctrl_next.disable_status;
      sleep_o    <= stopped && sleep_act && !ctrl_reg.disable_request;
    end
  end

  mdsc_stop_seq u_stop_seq (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .stop_i    (stop_req),
    .clk_en_o  (func_clk_en_o),
    .stopped_o (stopped)
  );

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic [31:0] rdata_next;
  logic [1:0]  rresp_next;
  logic        rvalid_next;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_word[MDSC_DISABLE_REQUEST_BIT] = ctrl_reg.disable_request;
    rd_word[MDSC_DISABLE_STATUS_BIT]  = ctrl_reg.disable_status;
    rd_word[MDSC_SLEEP_IGNORE_BIT]    = (VARIANT != MDSC_VAR_NONE) && ctrl_reg.sleep_ignore;
    rdata_next  = s_axi_rdata_o;
    rresp_next  = s_axi_rresp_o;
    rvalid_next = s_axi_rvalid_o;
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      if (s_axi_araddr_i == MDSC_CLOCK_CONTROL_OFFSET) begin
        rdata_next = rd_word;
        rresp_next = MDSC_RESP_OKAY;
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = MDSC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= MDSC_RESP_OKAY;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end else begin
      s_axi_rdata_o   <= rdata_next;
      s_axi_rresp_o   <= rresp_next;
      s_axi_rvalid_o  <= rvalid_next;
      s_axi_arready_o <= !rvalid_next;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_req_write;
    @(posedge clk_i) disable iff (srst_i)
      (wr_do && wr_hit && wstrb0_reg) |=>
        ctrl_reg.disable_request == $past(wdata_reg[MDSC_DISABLE_REQUEST_BIT]);
  endproperty
  a_req_write: assert property (p_req_write) else $error("disable request not stored");

  property p_status_clock_off;
    @(posedge clk_i) disable iff (srst_i)
      ctrl_reg.disable_status |-> !func_clk_en_o && $past(ctrl_reg.disable_request);
  endproperty
  a_status_clock_off: assert property (p_status_clock_off) else $error("status set with clock on");

  property p_sleep_obeyed;
    @(posedge clk_i) disable iff (srst_i)
      (sleep_req_i && !ign_eff && !ctrl_reg.disable_request)[*8] |-> sleep_o && !func_clk_en_o;
  endproperty
  a_sleep_obeyed: assert property (p_sleep_obeyed) else $error("sleep request not obeyed");

  property p_sleep_ignored;
    @(posedge clk_i) disable iff (srst_i)
      (ctrl_reg.sleep_ignore && !ctrl_reg.disable_request)[*3] |->
        (VARIANT != MDSC_VAR_FULL) || (!sleep_o && func_clk_en_o);
  endproperty
  a_sleep_ignored: assert property (p_sleep_ignored) else $error("sleep entered while ignored");

  property p_none_reads_zero;
    @(posedge clk_i) disable iff (srst_i)
      (s_axi_rvalid_o && VARIANT == MDSC_VAR_NONE) |-> !s_axi_rdata_o[MDSC_SLEEP_IGNORE_BIT];
  endproperty
  a_none_reads_zero: assert property (p_none_reads_zero) else $error("absent ignore bit reads one");

  property p_storage_no_effect;
    @(posedge clk_i) disable iff (srst_i)
      (VARIANT == MDSC_VAR_STORAGE && ctrl_reg.sleep_ignore && sleep_req_i
        && !ctrl_reg.disable_request)[*8] |-> sleep_o;
  endproperty
  a_storage_no_effect: assert property (p_storage_no_effect) else $error("stored bit blocked sleep");

  property p_disable_early;
    @(posedge clk_i) disable iff (srst_i)
      $rose(ctrl_reg.disable_request) |-> !ctrl_reg.disable_status;
  endproperty
  a_disable_early: assert property (p_disable_early) else $error("disable status early");

  property p_disable_done;
    @(posedge clk_i) disable iff (srst_i)
      $rose(ctrl_reg.disable_request) ##1 ctrl_reg.disable_request [*6] |=>
        ctrl_reg.disable_status;
  endproperty
  a_disable_done: assert property (p_disable_done) else $error("disable status late");

  property p_enable_back;
    @(posedge clk_i) disable iff (srst_i)
      $fell(ctrl_reg.disable_request) && !sleep_act |=> func_clk_en_o ##1 !ctrl_reg.disable_status;
  endproperty
  a_enable_back: assert property (p_enable_back) else $error("clock not restored");

  c_disable: cover property (@(posedge clk_i) disable iff (srst_i) $rose(disabled_o));
  c_sleep: cover property (@(posedge clk_i) disable iff (srst_i) $rose(sleep_o));
  c_bad_addr: cover property (@(posedge clk_i) disable iff (srst_i)
    s_axi_rvalid_o && s_axi_rresp_o == MDSC_RESP_SLVERR);

endmodule : mdsc_top
`default_nettype wire

// ---- verif/mdsc_top_tb_top.sv ----
// self-checking bench for the module disable and sleep control block
`timescale 1ns/1ps
`default_nettype none
module mdsc_top_tb_top
  import mdsc_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_i    = 1'b0;
  logic        srst_i   = 1'b1;
  logic [31:0] awaddr   = 32'h0000_0000;
  logic        awvalid  = 1'b0;
  logic        awready;
  logic [31:0] wdata    = 32'h0000_0000;
  logic [3:0]  wstrb    = 4'h0;
  logic        wvalid   = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready   = 1'b0;
  logic [31:0] araddr   = 32'h0000_0000;
  logic        arvalid  = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready   = 1'b0;
  logic        sleep_req = 1'b0;
  logic        clk_en;
  logic        sleep_st;
  logic        disabled;
  logic [31:0] rdata_stor;
  logic [31:0] rdata_none;
  logic        sleep_stor;
  logic        sleep_none;
  int          errors   = 0;
  int          checks   = 0;
  int          n;
  logic [1:0]  r;

  always #(MDSC_CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  mdsc_top #(.VARIANT(MDSC_VAR_FULL)) mdsc_top_inst (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sleep_req_i(sleep_req),
    .func_clk_en_o(clk_en), .sleep_o(sleep_st), .disabled_o(disabled)
  );

  // storage-only and absent ignore bit variants share the same bus stimulus
  mdsc_top #(.VARIANT(MDSC_VAR_STORAGE)) mdsc_top_storage_inst (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(), .s_axi_rdata_o(rdata_stor), .s_axi_rresp_o(),
    .s_axi_rvalid_o(), .s_axi_rready_i(rready), .sleep_req_i(sleep_req),
    .func_clk_en_o(), .sleep_o(sleep_stor), .disabled_o()
  );

  mdsc_top #(.VARIANT(MDSC_VAR_NONE)) mdsc_top_none_inst (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(), .s_axi_rdata_o(rdata_none), .s_axi_rresp_o(),
    .s_axi_rvalid_o(), .s_axi_rready_i(rready), .sleep_req_i(sleep_req),
    .func_clk_en_o(), .sleep_o(sleep_none), .disabled_o()
  );

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t ns %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    @(posedge clk_i);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, exp, "rdata");
    chk(32'(rresp), 32'(er), "rresp");
    rready <= 1'b0;
  endtask : rd_chk

  task automatic give_verdict;
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk(32'(clk_en), 32'h0000_0001, "clk_en");
    chk(32'(disabled), 32'h0000_0000, "disabled after reset");
    chk(32'(sleep_st), 32'h0000_0000, "sleep after reset");
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, MDSC_RESP_OKAY);
  endtask : t_reset

  task automatic t_disable;
    // status bit written too: must not stick
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0003, 4'hF, r);
    chk(32'(r), 32'(MDSC_RESP_OKAY), "bresp");
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0001, MDSC_RESP_OKAY);
    chk(32'(clk_en), 32'h0000_0000, "clk_en");
    chk(32'(disabled), 32'h0000_0000, "early status");
    for (n = 0; n < 20 && disabled !== 1'b1; n++) @(posedge clk_i);
    chk(32'(disabled), 32'h0000_0001, "disabled");
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0003, MDSC_RESP_OKAY);
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, 4'hF, r);
    for (n = 0; n < 10 && disabled !== 1'b0; n++) @(posedge clk_i);
    chk(32'(clk_en), 32'h0000_0001, "clk_en back");
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, MDSC_RESP_OKAY);
  endtask : t_disable

  task automatic t_sleep;
    sleep_req <= 1'b1;
    for (n = 0; n < 20 && sleep_st !== 1'b1; n++) @(posedge clk_i);
    chk(32'(sleep_st), 32'h0000_0001, "sleep");
    chk(32'(clk_en), 32'h0000_0000, "clk_en");
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, MDSC_RESP_OKAY);
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0008, 4'hF, r);
    for (n = 0; n < 10 && sleep_st !== 1'b0; n++) @(posedge clk_i);
    repeat (10) @(posedge clk_i);
    chk(32'(clk_en), 32'h0000_0001, "clk_en ignored");
    chk(32'(sleep_st), 32'h0000_0000, "sleep ignored");
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0008, MDSC_RESP_OKAY);
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0009, 4'hF, r);
    for (n = 0; n < 20 && disabled !== 1'b1; n++) @(posedge clk_i);
    chk(32'(disabled), 32'h0000_0001, "disabled");
    chk(32'(sleep_st), 32'h0000_0000, "sleep");
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_000B, MDSC_RESP_OKAY);
    sleep_req <= 1'b0;
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, 4'hF, r);
    for (n = 0; n < 10 && disabled !== 1'b0; n++) @(posedge clk_i);
    chk(32'(clk_en), 32'h0000_0001, "clk_en");
  endtask : t_sleep

  task automatic t_bus_edges;
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0009, 4'h0, r);
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, MDSC_RESP_OKAY);
    axi_write(32'h0000_0004, 32'h0000_0001, 4'hF, r);
    chk(32'(r), 32'(MDSC_RESP_SLVERR), "bresp unmapped");
    rd_chk(32'h0000_0004, 32'h0000_0000, MDSC_RESP_SLVERR);
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, MDSC_RESP_OKAY);
    chk(32'(disabled), 32'h0000_0000, "disabled");
  endtask : t_bus_edges

  task automatic t_variants;
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0008, 4'hF, r);
    rd_chk(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0008, MDSC_RESP_OKAY);
    // read data holds after the handshake in every instance
    chk(rdata_stor, 32'h0000_0008, "storage readback");
    chk(rdata_none, 32'h0000_0000, "absent bit readback");
    sleep_req <= 1'b1;
    for (n = 0; n < 20 && sleep_stor !== 1'b1; n++) @(posedge clk_i);
    chk(32'(sleep_stor), 32'h0000_0001, "storage sleep");
    chk(32'(sleep_none), 32'h0000_0001, "absent bit sleep");
    chk(32'(sleep_st), 32'h0000_0000, "full variant ignores");
    chk(32'(clk_en), 32'h0000_0001, "full variant clock");
    sleep_req <= 1'b0;
    axi_write(MDSC_CLOCK_CONTROL_OFFSET, 32'h0000_0000, 4'hF, r);
  endtask : t_variants

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_disable();
    t_sleep();
    t_bus_edges();
    t_variants();
    give_verdict();
  end

  initial begin
    #(MDSC_CLK_PERIOD_NS * 5000);
    errors++;
    give_verdict();
  end

endmodule : mdsc_top_tb_top
`default_nettype wire
